// ==== logic/imt_master.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - Each frame is eight data bits then one acknowledge bit, low meaning acknowledge.
// - First frame after start or restart is the address frame.
// - Start is data falling with clock high; stop is data rising with clock high.
// - Start request when bus free issues start, sets busy and start flags.
// - Start seen with matching driven level sets master, transmit, transmit-empty.
// - Transmit write clears empty; load into shift register sets empty again.
// - Address with read direction: ninth rise clears transmit, empty; sets receive-full.
// - Ten-bit read uses restart then pattern byte with read bit.
// - Transmitting master holds clock low while no byte is ready.
// - Transmit-end set when byte ends with nothing queued; then stop allowed.
// - Stop detect clears master, transmit, empty, end; sets stop flag.
// - Entering receive, a dummy read starts clocking and reception.
// - Receive-full set at eighth or ninth rise by timing bit; read clears.
// - Receive acknowledge slot carries the acknowledge-value bit, one meaning not-acknowledge.
// - Wait bit holds clock low after final byte so stop can follow.
// - Stop request then last read releases wait; stop follows the low period.
// - Stop detect in receive clears master and transmit, sets stop flag.
// - Byte completing while receive-full set holds clock low before the flag point.
// - High and low clock periods are counted from the period settings.
module imt_master (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic interface_enable_i,
  input wire logic module_reset_bit_i,
  input wire logic start_req_set_i,
  input wire logic stop_req_set_i,
  input wire logic clr_start_i,
  input wire logic clr_stop_i,
  input wire logic clr_nack_i,
  input wire logic tx_wr_i,
  input wire logic [7:0] tx_data_i,
  input wire logic rx_rd_i,
  input wire logic ack_value_bit_i,
  input wire logic receive_flag_timing_bit_i,
  input wire logic wait_bit_i,
  input wire logic [4:0] clock_high_period_i,
  input wire logic [4:0] clock_low_period_i,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic [7:0] rx_data_o,
  output logic bus_busy_flag_o,
  output logic start_detected_o,
  output logic stop_detected_o,
  output logic master_select_bit_o,
  output logic transmit_select_bit_o,
  output logic transmit_empty_flag_o,
  output logic transmit_end_flag_o,
  output logic receive_full_flag_o,
  output logic not_acknowledged_flag_o,
  output logic start_request_bit_o,
  output logic stop_request_bit_o
);
  import imt_pkg::*;

  // ***************************************************************
  // Line sampling
  // ***************************************************************
  logic scl_s, sda_s;

  imt_sync u_scl_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(scl_i),
    .q_o(scl_s)
  );

  imt_sync u_sda_sync (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(sda_i),
    .q_o(sda_s)
  );

  // ***************************************************************
  // State
  // ***************************************************************
  imt_state_e state_q, state_d;
  logic [4:0] cnt_q, cnt_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] shift_q, shift_d, txbuf_q, txbuf_d, rxbuf_q, rxbuf_d;
  logic scl_low_q, scl_low_d, sda_low_q, sda_low_d, scl_p_q, sda_p_q;
  logic bus_busy_flag_q, bus_busy_flag_d, startf_q, startf_d, stopf_q, stopf_d;
  logic mst_q, mst_d, trs_q, trs_d, transmit_empty_flag_q, transmit_empty_flag_d, transmit_end_flag_q, transmit_end_flag_d;
  logic receive_full_flag_q, receive_full_flag_d, nack_q, nack_d, streq_q, streq_d, spreq_q, spreq_d;
  logic first_q, first_d, dir_q, dir_d, gate_q, gate_d;
  logic soft_rst, scl_rise, scl_fall, start_det, stop_det, end_bit, receive_full_flag_set;
  logic [3:0] receive_full_flag_idx;

  assign soft_rst = module_reset_bit_i || !interface_enable_i;
  assign scl_rise = scl_s && !scl_p_q;
  assign scl_fall = !scl_s && scl_p_q;
  assign start_det = scl_s && scl_p_q && sda_p_q && !sda_s;
  assign stop_det = scl_s && scl_p_q && !sda_p_q && sda_s;
  assign receive_full_flag_idx = receive_flag_timing_bit_i ? LAST_DATA_IDX : ACK_IDX;

  // ***************************************************************
  // Next-state logic
  // ***************************************************************
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    bit_d = bit_q;
    shift_d = shift_q;
    txbuf_d = txbuf_q;
    rxbuf_d = rxbuf_q;
    scl_low_d = scl_low_q;
    sda_low_d = sda_low_q;
    bus_busy_flag_d = bus_busy_flag_q;
    startf_d = startf_q;
    stopf_d = stopf_q;
    mst_d = mst_q;
    trs_d = trs_q;
    transmit_empty_flag_d = transmit_empty_flag_q;
    transmit_end_flag_d = transmit_end_flag_q;
    receive_full_flag_d = receive_full_flag_q;
    nack_d = nack_q;
    streq_d = streq_q;
    spreq_d = spreq_q;
    first_d = first_q;
    dir_d = dir_q;
    gate_d = gate_q;
    receive_full_flag_set = 1'b0;
    end_bit = 1'b0;
    if (start_req_set_i) begin
      streq_d = 1'b1;
    end
    if (stop_req_set_i) begin
      spreq_d = 1'b1;
    end
    if (clr_start_i) begin
      startf_d = 1'b0;
    end
    if (clr_stop_i) begin
      stopf_d = 1'b0;
    end
    if (clr_nack_i) begin
      nack_d = 1'b0;
    end
    if (tx_wr_i) begin
      txbuf_d = tx_data_i;
      transmit_empty_flag_d = 1'b0;
      transmit_end_flag_d = 1'b0;
    end
    if (rx_rd_i) begin
      receive_full_flag_d = 1'b0;
    end
    case (state_q)
      S_IDLE: begin
        scl_low_d = 1'b0;
        sda_low_d = 1'b0;
        if (streq_q && !bus_busy_flag_q) begin
          state_d = S_START;
          cnt_d = CNT_RST;
        end
      end
      S_START: begin
        scl_low_d = 1'b0;
        if (scl_s) begin
          if (cnt_q != clock_high_period_i) begin
            cnt_d = cnt_q + CNT_STEP;
          end else if (!sda_low_q) begin
            sda_low_d = 1'b1;
            cnt_d = CNT_RST;
          end else begin
            scl_low_d = 1'b1;
            state_d = S_HOLD;
          end
        end
      end
      S_HOLD: begin
        scl_low_d = 1'b1;
        sda_low_d = 1'b0;
        cnt_d = CNT_RST;
        bit_d = FIRST_IDX;
        if (spreq_q && (trs_q || !receive_full_flag_q)) begin
          state_d = S_STOPL;
          sda_low_d = 1'b1;
        end else if (streq_q) begin
          state_d = S_RSTRT;
          sda_low_d = 1'b0;
        end else if (trs_q && !transmit_empty_flag_q && !nack_q) begin
          shift_d = {txbuf_q[6:0], 1'b0};
          dir_d = txbuf_q[0];
          sda_low_d = !txbuf_q[7];
          transmit_empty_flag_d = 1'b1;
          state_d = S_LOW;
        end else if (!trs_q && mst_q && !spreq_q && (!receive_full_flag_q || (!wait_bit_i && !gate_q))) begin
          gate_d = 1'b0;
          sda_low_d = 1'b0;
          state_d = S_LOW;
        end
      end
      S_RSTRT, S_STOPL, S_LOW: begin
        scl_low_d = 1'b1;
        // Data moves one cycle after the clock is pulled low, never with it
        if (state_q == S_LOW && cnt_q == CNT_RST && bit_q != FIRST_IDX) begin
          if (bit_q == ACK_IDX) begin
            sda_low_d = trs_q ? 1'b0 : !ack_value_bit_i;
          end else if (trs_q) begin
            sda_low_d = !shift_q[7];
            shift_d = {shift_q[6:0], 1'b0};
          end
        end
        if (cnt_q != clock_low_period_i) begin
          cnt_d = cnt_q + CNT_STEP;
        end else if (state_q == S_RSTRT) begin
          scl_low_d = 1'b0;
          cnt_d = CNT_RST;
          state_d = S_START;
        end else if (state_q == S_STOPL) begin
          scl_low_d = 1'b0;
          cnt_d = CNT_RST;
          state_d = S_STOPH;
        end else if (!(!trs_q && !first_q && bit_q == receive_full_flag_idx && receive_full_flag_q)) begin
          scl_low_d = 1'b0;
          cnt_d = CNT_RST;
          state_d = S_HIGH;
        end
      end
      S_HIGH: begin
        scl_low_d = 1'b0;
        if (scl_rise) begin
          if (bit_q == ACK_IDX) begin
            if (trs_q && sda_s) begin
              nack_d = 1'b1;
            end
            if (trs_q && first_q && dir_q) begin
              trs_d = 1'b0;
              transmit_empty_flag_d = 1'b0;
              receive_full_flag_d = 1'b1;
              gate_d = 1'b1;
            end
            if (!trs_q && receive_full_flag_idx == ACK_IDX) begin
              rxbuf_d = shift_q;
              receive_full_flag_d = 1'b1;
              receive_full_flag_set = 1'b1;
            end
          end else if (!trs_q) begin
            shift_d = {shift_q[6:0], sda_s};
            if (bit_q == LAST_DATA_IDX && receive_full_flag_idx == LAST_DATA_IDX) begin
              rxbuf_d = {shift_q[6:0], sda_s};
              receive_full_flag_d = 1'b1;
              receive_full_flag_set = 1'b1;
            end
          end
        end
        if (scl_s && cnt_q != clock_high_period_i) begin
          cnt_d = cnt_q + CNT_STEP;
        end
        end_bit = (scl_s && cnt_q == clock_high_period_i) || scl_fall;
        if (end_bit) begin
          scl_low_d = 1'b1;
          cnt_d = CNT_RST;
          if (bit_q != ACK_IDX) begin
            bit_d = bit_q + 4'h1;
            state_d = S_LOW;
          end else begin
            first_d = 1'b0;
            transmit_end_flag_d = trs_q && transmit_empty_flag_q;
            state_d = S_HOLD;
          end
        end
      end
      S_STOPH: begin
        scl_low_d = 1'b0;
        if (scl_s) begin
          if (cnt_q != clock_high_period_i) begin
            cnt_d = cnt_q + CNT_STEP;
          end else begin
            sda_low_d = 1'b0;
            state_d = S_IDLE;
          end
        end
      end
      default: begin
        state_d = S_IDLE;
      end
    endcase
    if (start_det) begin
      bus_busy_flag_d = 1'b1;
      startf_d = 1'b1;
      first_d = 1'b1;
      if (streq_q && sda_low_q) begin
        streq_d = 1'b0;
        mst_d = 1'b1;
        trs_d = 1'b1;
        transmit_empty_flag_d = 1'b1;
      end
    end
    if (stop_det) begin
      bus_busy_flag_d = 1'b0;
      stopf_d = 1'b1;
      mst_d = 1'b0;
      trs_d = 1'b0;
      transmit_empty_flag_d = 1'b0;
      transmit_end_flag_d = 1'b0;
      spreq_d = 1'b0;
      state_d = S_IDLE;
      scl_low_d = 1'b0;
      sda_low_d = 1'b0;
    end
  end

  // ***************************************************************
  // Registers
  // ***************************************************************
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i || soft_rst) begin
      state_q <= S_IDLE;
      cnt_q <= CNT_RST;
      bit_q <= FIRST_IDX;
      shift_q <= BYTE_RST;
      txbuf_q <= BYTE_RST;
      rxbuf_q <= BYTE_RST;
      scl_low_q <= FLAG_RST;
      sda_low_q <= FLAG_RST;
      scl_p_q <= LINE_IDLE;
      sda_p_q <= LINE_IDLE;
      bus_busy_flag_q <= FLAG_RST;
      startf_q <= FLAG_RST;
      stopf_q <= FLAG_RST;
      mst_q <= FLAG_RST;
      trs_q <= FLAG_RST;
      transmit_empty_flag_q <= FLAG_RST;
      transmit_end_flag_q <= FLAG_RST;
      receive_full_flag_q <= FLAG_RST;
      nack_q <= FLAG_RST;
      streq_q <= FLAG_RST;
      spreq_q <= FLAG_RST;
      first_q <= FLAG_RST;
      dir_q <= FLAG_RST;
      gate_q <= FLAG_RST;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      bit_q <= bit_d;
      shift_q <= shift_d;
      txbuf_q <= txbuf_d;
      rxbuf_q <= rxbuf_d;
      scl_low_q <= scl_low_d;
      sda_low_q <= sda_low_d;
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
      bus_busy_flag_q <= bus_busy_flag_d;
      startf_q <= startf_d;
      stopf_q <= stopf_d;
      mst_q <= mst_d;
      trs_q <= trs_d;
      transmit_empty_flag_q <= transmit_empty_flag_d;
      transmit_end_flag_q <= transmit_end_flag_d;
      receive_full_flag_q <= receive_full_flag_d;
      nack_q <= nack_d;
      streq_q <= streq_d;
      spreq_q <= spreq_d;
      first_q <= first_d;
      dir_q <= dir_d;
      gate_q <= gate_d;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe_o = scl_low_q;
  assign sda_oe_o = sda_low_q;
  assign rx_data_o = rxbuf_q;
  assign bus_busy_flag_o = bus_busy_flag_q;
  assign start_detected_o = startf_q;
  assign stop_detected_o = stopf_q;
  assign master_select_bit_o = mst_q;
  assign transmit_select_bit_o = trs_q;
  assign transmit_empty_flag_o = transmit_empty_flag_q;
  assign transmit_end_flag_o = transmit_end_flag_q;
  assign receive_full_flag_o = receive_full_flag_q;
  assign not_acknowledged_flag_o = nack_q;
  assign start_request_bit_o = streq_q;
  assign stop_request_bit_o = spreq_q;

  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i || soft_rst);

  AST_START_BUSY: assert property (start_det |=> bus_busy_flag_q && startf_q)
    else $error("start seen but busy or start flag not set");
  AST_MASTER_TX: assert property (start_det && streq_q && sda_low_q
      |=> mst_q && trs_q && transmit_empty_flag_q && !streq_q)
    else $error("own start did not enter master transmit");
  AST_STOP_CLEARS: assert property (stop_det
      |=> !mst_q && !trs_q && !transmit_empty_flag_q && !transmit_end_flag_q && stopf_q)
    else $error("stop did not clear mode bits or set stop flag");
  AST_STOP_FREE: assert property (stop_det |=> !bus_busy_flag_q ##1 state_q == S_IDLE || start_det)
    else $error("bus busy kept after stop");
  AST_TX_WRITE: assert property (tx_wr_i && !start_det && !stop_det |=> !transmit_empty_flag_q)
    else $error("transmit write did not clear empty flag");
  AST_ADDR_READ: assert property (state_q == S_HIGH && scl_rise && bit_q == ACK_IDX
      && first_q && dir_q && trs_q && !stop_det |=> !trs_q && receive_full_flag_q && !transmit_empty_flag_q)
    else $error("read address did not enter receive");
  AST_TX_HOLD: assert property (state_q == S_HOLD && trs_q && transmit_empty_flag_q && !spreq_q
      && !streq_q && !stop_det |=> state_q == S_HOLD && scl_low_q)
    else $error("clock released with no transmit byte");
  AST_RX_STALL: assert property (state_q == S_LOW && !trs_q && !first_q && receive_full_flag_q
      && bit_q == receive_full_flag_idx && !rx_rd_i && !stop_det |=> state_q == S_LOW && scl_low_q)
    else $error("clock released while receive buffer full");
  AST_RX_READ: assert property (rx_rd_i && !receive_full_flag_set && !(state_q == S_HIGH)
      |=> !receive_full_flag_q)
    else $error("receive read did not clear full flag");
  AST_HIGH_ENTRY: assert property ($rose(state_q == S_HIGH)
      |-> $past(cnt_q) == $past(clock_low_period_i))
    else $error("low period not counted out");
  AST_STOP_EDGE: assert property ($fell(sda_low_q) && $past(state_q) == S_STOPH
      |-> !scl_low_q && $past(scl_s))
    else $error("stop released data with clock low");

  COV_MASTER: cover property (start_det && streq_q && sda_low_q);
  COV_RX_MODE: cover property (trs_q ##1 !trs_q && receive_full_flag_q && mst_q);
  COV_RX_STALL: cover property (state_q == S_LOW && !trs_q && receive_full_flag_q && bit_q == receive_full_flag_idx);
  COV_STOP: cover property (stop_det && mst_q);

endmodule

// ==== logic/imt_pkg.sv ====
package imt_pkg;

  // ***************************************************************
  // Engine states
  // ***************************************************************
  typedef enum logic [2:0] {
    S_IDLE  = 3'b000,
    S_START = 3'b001,
    S_LOW   = 3'b010,
    S_HIGH  = 3'b011,
    S_HOLD  = 3'b100,
    S_RSTRT = 3'b101,
    S_STOPL = 3'b110,
    S_STOPH = 3'b111
  } imt_state_e;

  // ***************************************************************
  // Frame layout and reset values
  // ***************************************************************
  localparam logic [3:0] FIRST_IDX = 4'h0;
  localparam logic [3:0] LAST_DATA_IDX = 4'h7;
  localparam logic [3:0] ACK_IDX = 4'h8;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [4:0] CNT_RST = 5'h00;
  localparam logic [4:0] CNT_STEP = 5'h01;
  localparam logic FLAG_RST = 1'b0;
  localparam logic LINE_IDLE = 1'b1;

endpackage

// ==== logic/imt_sync.sv ====
`timescale 1ns/1ps
module imt_sync (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic d_i,
  output logic q_o
);
  import imt_pkg::*;

  logic meta_q;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      meta_q <= LINE_IDLE;
      q_o <= LINE_IDLE;
    end else begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end

endmodule

// ==== tb/imt_master_bench.sv ====
`timescale 1ns/1ps
module imt_master_bench;
  import imt_pkg::*;
  `define CHK(g, e, m) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
    $display("unexpected at %0t: %s", $time, m); end end
  localparam int BUSY = 0, SDET = 1, PDET = 2, MSTR = 3, XMIT = 4, TXE = 5;
  localparam int TXEND = 6, RXF = 7, NACK = 8, STRQ = 9, SPRQ = 10;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic en = 1'b0;
  logic mrst = 1'b1;
  logic ackv = 1'b0;
  logic rfs = 1'b0;
  logic wt = 1'b0;
  logic [6:0] req = 7'h00;
  logic [7:0] txd = 8'h00;
  logic [4:0] hi_per = 5'h03;
  logic [4:0] lo_per = 5'h03;
  logic [31:0] stretch = 32'h0;
  logic scl_oe, sda_oe, s_scl_oe, s_sda_oe;
  logic [7:0] rxd;
  wire [10:0] fl;
  wire scl = ~(scl_oe | s_scl_oe);
  wire sda = ~(sda_oe | s_sda_oe);
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int seed = 50577;
  logic [7:0] exp_q[$];

  always #20 clk = ~clk;

  imt_master dut (
    .ref_clk_i(clk), .rst_n_i(rst_n), .interface_enable_i(en), .module_reset_bit_i(mrst),
    .start_req_set_i(req[0]), .stop_req_set_i(req[1]), .clr_start_i(req[2]),
    .clr_stop_i(req[3]), .clr_nack_i(req[4]), .tx_wr_i(req[5]), .tx_data_i(txd),
    .rx_rd_i(req[6]), .ack_value_bit_i(ackv), .receive_flag_timing_bit_i(rfs),
    .wait_bit_i(wt), .clock_high_period_i(hi_per), .clock_low_period_i(lo_per),
    .scl_i(scl), .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe),
    .rx_data_o(rxd), .bus_busy_flag_o(fl[BUSY]), .start_detected_o(fl[SDET]),
    .stop_detected_o(fl[PDET]), .master_select_bit_o(fl[MSTR]),
    .transmit_select_bit_o(fl[XMIT]), .transmit_empty_flag_o(fl[TXE]),
    .transmit_end_flag_o(fl[TXEND]), .receive_full_flag_o(fl[RXF]),
    .not_acknowledged_flag_o(fl[NACK]), .start_request_bit_o(fl[STRQ]),
    .stop_request_bit_o(fl[SPRQ])
  );

  imt_slave_model #(.ADDR(7'h78)) slv (
    .scl_i(scl), .sda_i(sda), .stretch_i(stretch), .scl_oe_o(s_scl_oe), .sda_oe_o(s_sda_oe)
  );

  // ***************************************************************
  // Shared tasks
  // ***************************************************************
  function automatic logic exp_ack(input int i, input int n);
    return (i == n - 1);
  endfunction

  task automatic report_and_stop();
    if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      fail_count++;
      $display("unexpected at %0t: timeout", $time);
      report_and_stop();
    end
  end

  task automatic wait_on(input int k, input logic v);
    do @(negedge clk); while (fl[k] !== v);
  endtask

  task automatic pulse(input int k, input logic [7:0] d = 8'h00);
    @(posedge clk);
    txd <= d;
    req[k] <= 1'b1;
    @(posedge clk);
    req[k] <= 1'b0;
  endtask

  task automatic send(input logic [7:0] d);
    wait_on(TXE, 1'b1);
    pulse(5, d);
  endtask

  task automatic start_xfer();
    wait_on(BUSY, 1'b0);
    pulse(0);
    wait_on(MSTR, 1'b1);
    repeat (2) @(negedge clk);
    `CHK(fl[XMIT], 1'b1, "not in transmit mode")
    `CHK(fl[TXE], 1'b1, "transmit empty low")
    `CHK({fl[BUSY], fl[SDET], fl[STRQ]}, 3'b110, "start flags")
  endtask

  task automatic stop_xfer();
    wait_on(PDET, 1'b1);
    repeat (2) @(negedge clk);
    `CHK({fl[MSTR], fl[XMIT], fl[TXE], fl[TXEND], fl[SPRQ]}, 5'h00, "mode after stop")
    `CHK(fl[BUSY], 1'b0, "bus still busy")
    pulse(3);
    pulse(4);
    pulse(2);
    repeat (2) @(negedge clk);
    `CHK({fl[PDET], fl[NACK]}, 2'b00, "flags not cleared")
    slv.rx_q.delete();
    slv.mack_q.delete();
    exp_q.delete();
  endtask

  // ***************************************************************
  // Scenarios
  // ***************************************************************
  task automatic write_xfer(input int n);
    logic [7:0] d;
    start_xfer();
    pulse(5, 8'hF0);
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      exp_q.push_back(d);
      send(d);
      if (i == 1) begin
        repeat (2) @(negedge clk);
        `CHK(fl[TXE], 1'b0, "empty after write")
      end
    end
    wait_on(TXEND, 1'b1);
    repeat (40) @(negedge clk);
    `CHK({scl_oe, fl[NACK]}, 2'b10, "clock not held or nack")
    pulse(1);
    wait_on(PDET, 1'b1);
    `CHK(slv.rx_q.size(), n, "byte count at slave")
    foreach (exp_q[i]) `CHK(slv.rx_q[i], exp_q[i], "byte at slave")
    stop_xfer();
  endtask

  task automatic read_xfer(input int n);
    logic [7:0] d[$];
    start_xfer();
    send(8'hF0);
    send(8'($random(seed)));
    wait_on(TXEND, 1'b1);
    pulse(2);
    pulse(0);
    wait_on(SDET, 1'b1);
    send(8'hF1);
    wait_on(RXF, 1'b1);
    repeat (2) @(negedge clk);
    `CHK({fl[XMIT], fl[TXE]}, 2'b00, "receive mode entry")
    for (int i = 0; i < n; i++) begin
      d.push_back(8'($random(seed)));
      slv.tx_q.push_back(d[i]);
    end
    pulse(6);
    for (int i = 0; i < n; i++) begin
      wait_on(RXF, 1'b1);
      `CHK(slv.mack_q.size(), i + (rfs ? 0 : 1), "flag timing")
      @(posedge clk);
      if (i == n - 2) wt <= 1'b1;
      if (i == (rfs ? n - 1 : n - 2)) ackv <= 1'b1;
      if (i == 0 || i == n - 1) begin
        repeat (300) @(negedge clk);
        `CHK(scl_oe, 1'b1, "clock not held low")
      end
      if (i == n - 1) pulse(1);
      pulse(6);
      repeat (2) @(negedge clk);
      `CHK(rxd, d[i], "received byte")
    end
    wait_on(PDET, 1'b1);
    @(posedge clk);
    wt <= 1'b0;
    ackv <= 1'b0;
    foreach (d[i]) `CHK(slv.mack_q[i], exp_ack(i, n), "acknowledge value")
    stop_xfer();
  endtask

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    en <= 1'b1;
    @(posedge clk);
    mrst <= 1'b0;
    repeat (4) @(negedge clk);
    `CHK({fl, scl_oe, sda_oe}, 13'h0000, "state after reset")
    write_xfer(3);
    start_xfer();
    pulse(5, 8'h54);
    wait_on(NACK, 1'b1);
    `CHK(fl[MSTR], 1'b1, "master lost after nack")
    pulse(1);
    stop_xfer();
    for (int r = 0; r < 2; r++) begin
      @(posedge clk);
      rfs <= r[0];
      stretch <= 32'(($random(seed) & 3) * 160);
      read_xfer(3);
    end
    report_and_stop();
  end
endmodule

// ==== tb/imt_slave_model.sv ====
`timescale 1ns/1ps
module imt_slave_model #(
  parameter logic [6:0] ADDR = 7'h78
) (
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic [31:0] stretch_i,
  output logic scl_oe_o = 1'b0,
  output logic sda_oe_o = 1'b0
);
  // ***************************************************************
  // Bus slave on pulled-up open-drain lines
  // ***************************************************************
  logic [7:0] sh = 8'h00;
  logic [7:0] out = 8'hFF;
  logic sel = 1'b0;
  logic rd = 1'b0;
  logic first = 1'b0;
  logic mrx = 1'b0;
  int cnt = 0;
  logic [7:0] rx_q[$];
  logic [7:0] tx_q[$];
  logic mack_q[$];

  always @(negedge sda_i) if (scl_i === 1'b1) begin
    cnt = 0;
    first = 1'b1;
    rd = 1'b0;
  end

  always @(posedge sda_i) if (scl_i === 1'b1) begin
    sel = 1'b0;
    rd = 1'b0;
  end

  always @(posedge scl_i) begin
    if (cnt < 8) sh = {sh[6:0], sda_i};
    else if (mrx) begin
      mack_q.push_back(sda_i);
      if (sda_i) rd = 1'b0;
    end
    cnt = (cnt < 8) ? cnt + 1 : 0;
  end

  always @(negedge scl_i) begin
    if (cnt == 8) begin
      if (first) begin
        sel = (sh[7:1] == ADDR);
        rd = sel & sh[0];
        first = 1'b0;
      end else if (sel && !rd) rx_q.push_back(sh);
      sda_oe_o = sel & ~mrx;
    end else begin
      if (cnt == 0) begin
        mrx = rd & sel;
        if (mrx) out = tx_q.size() ? tx_q.pop_front() : 8'hFF;
      end
      sda_oe_o = mrx & ~out[7 - cnt];
    end
  end

  // Slow answer: stretch the low phase of the clock
  always @(negedge scl_i) if (stretch_i != 0) begin
    scl_oe_o = 1'b1;
    #(stretch_i);
    scl_oe_o = 1'b0;
  end
endmodule
